// [hdl/pmw_pkg.sv]
// package for the power mode and wake controller
package pmw_pkg;
  // register byte offsets
  localparam logic [7:0] PMW_CTRL_OFS    = 8'h00; // system_clock_control
  localparam logic [7:0] PMW_STAT_OFS    = 8'h04; // status flags
  localparam logic [7:0] PMW_WAKE_OFS    = 8'h08; // porta_wake_enable
  localparam logic [7:0] PMW_IRQEN_OFS   = 8'h0c; // interrupt enables
  localparam logic [7:0] PMW_FASTRC_OFS  = 8'h10; // fast_rc_control
  localparam logic [7:0] PMW_FASTXT_OFS  = 8'h14; // fast_crystal_control
  localparam logic [7:0] PMW_CMD_OFS     = 8'h18; // command strobes
  // system_clock_control fields
  localparam int PMW_CKS_LSB  = 5;
  localparam int PMW_FSS_BIT  = 2;
  localparam int PMW_FHK_BIT  = 1;
  localparam int PMW_FSK_BIT  = 0;
  localparam logic [2:0] PMW_CKS_SLOW = 3'h7;
  localparam logic [7:0] PMW_CTRL_RST = 8'h00;
  // fast_rc_control fields
  localparam int PMW_FRC_EN_BIT = 0;
  localparam int PMW_FRC_FL_BIT = 1;
  localparam int PMW_FRC_FQ_LSB = 2;
  localparam logic [3:0] PMW_FRC_RST = 4'h1;
  // fast_crystal_control fields
  localparam int PMW_FXT_EN_BIT = 0;
  localparam int PMW_FXT_FL_BIT = 1;
  // status fields
  localparam int PMW_ST_PDF_BIT = 0;
  localparam int PMW_ST_TO_BIT  = 1;
  localparam int PMW_ST_MODE_LSB = 4;
  // command bits
  localparam int PMW_CMD_WDCLR_BIT = 0;
  // settle times
  localparam int PMW_CLK_MHZ     = 125;
  localparam int PMW_FAST_SET_NS = 1000;
  localparam int PMW_SLOW_SET_NS = 2000;
  localparam int PMW_FAST_SET_CYC = (PMW_FAST_SET_NS * PMW_CLK_MHZ + 999) / 1000;
  localparam int PMW_SLOW_SET_CYC = (PMW_SLOW_SET_NS * PMW_CLK_MHZ + 999) / 1000;
  // operating modes
  typedef enum logic [2:0] {
    PMW_NORMAL, PMW_SLOW, PMW_SLEEP, PMW_IDLE_SLOW_ONLY, PMW_IDLE_BOTH_CLOCKS, PMW_IDLE_FAST_ONLY
  } pmw_mode_e;
  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pmw_apb_req_s;
  // clock gate outputs
  typedef struct packed {
    logic       fast_on;
    logic       slow_on;
    logic       slow_rc_on;
    logic       slow_is_crystal;
    logic       sys_is_slow;
    logic [2:0] fast_div;
    logic       cpu_run;
  } pmw_clk_s;
endpackage : pmw_pkg

// [hdl/pmw_ctrl.sv]
// power mode and wake controller with apb registers
`timescale 1ns/1ns
// Overview of operation
// (RULE_01) code 111 selects slow clock
// (RULE_02) slow source chosen, wait until stable
// (RULE_03) codes 000-110 divide fast clock
// (RULE_04) back to normal waits fast stable
// (RULE_05) halt with keeps 00: sleep
// (RULE_06) halt keeps 01: fast off, slow on
// (RULE_07) halt keeps 11: both clocks run
// (RULE_08) halt keeps 10: fast on, slow off
// (RULE_09) halted modes stop execution, keep state
// (RULE_10) halt sets power-down, clears timeout
// (RULE_11) halt clears watchdog, counting continues
// (RULE_12) wake by port edge, interrupt, overflow
// (RULE_13) power-down cleared by reset or clear
// (RULE_14) overflow while halted sets timeout, resets pc
// (RULE_15) per-pin wake enable, resume after halt
// (RULE_16) disabled interrupt resumes, stays pending
// (RULE_17) enabled interrupt gets normal response
// (RULE_18) already-pending interrupt cannot wake
// (RULE_19) slow rc runs while watchdog enabled
// (RULE_20) fast rc stable flag clears then sets
// (RULE_21) halt strobe samples keep bits once
// (RULE_22) async wake edges synchronised first
module pmw_ctrl
  import pmw_pkg::*;
#(
  parameter int NPINS = 8,   // port a pins
  parameter int NIRQ  = 8    // interrupt sources
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              halt_strobe,
  input  wire logic              wdt_clear_strobe,
  input  wire logic              wdt_overflow,
  input  wire logic              wdt_enabled,
  input  wire logic              stack_full,
  input  wire logic [NPINS-1:0]  porta_pin,
  input  wire logic [NIRQ-1:0]   irq_flag,
  output logic                   cpu_run,
  output logic                   wdt_clear,
  output logic                   pc_sp_reset,
  output logic                   wake_resume,
  output logic                   irq_take,
  output pmw_clk_s               clk_ctl
);

  pmw_mode_e mode_r;                           // current operating mode
  logic [2:0]  cks_r;                          // system_clock_select
  logic        fss_r;                          // slow_source_select
  logic        fhk_r;                          // fast_keep_bit
  logic        fsk_r;                          // slow_keep_bit
  logic        pdf_r;                          // power_down_flag
  logic        to_r;                           // timeout_flag
  logic [NPINS-1:0] porta_wake_enable_r;                    // porta_wake_enable
  logic [NIRQ-1:0]  irqen_r;                   // interrupt enables
  logic [NIRQ-1:0]  pre_r;                     // flags already set at halt
  logic [1:0]  frc_fq_r;                       // fast rc frequency
  logic        frc_en_r;                       // fast rc enable
  logic        frc_fl_r;                       // fast_rc_stable_flag
  logic        fxt_en_r;                       // fast crystal enable
  logic        fxt_fl_r;                       // fast_crystal_stable_flag
  logic [15:0] fcnt_r;                         // fast settle counter
  logic [15:0] scnt_r;                         // slow settle counter
  logic        sstab_r;                        // slow osc stable
  logic        sreq_r;                         // slow switch pending
  logic [NPINS-1:0] pa_s1_r, pa_s2_r, pa_s3_r; // pin synchronisers
  logic        halted;                         // any low-power mode
  logic        fast_stable;                    // either fast osc stable
  logic        wr, rd;                         // apb access strobes
  logic        pin_wake, irq_wake, any_wake;   // wake sources
  logic [NIRQ-1:0] irq_live;                   // eligible interrupts

  // slave answers in one access cycle, no wait states
  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign halted  = (mode_r != PMW_NORMAL) && (mode_r != PMW_SLOW);
  assign fast_stable = frc_fl_r | fxt_fl_r;

  // addresses past the command register error out
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable && paddr > PMW_CMD_OFS) begin
      pslverr = 1'b1;
    end
  end

  // pin synchroniser; first stage read only by second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_s1_r <= '1;
      pa_s2_r <= '1;
      pa_s3_r <= '1;
    end else begin
      pa_s1_r <= porta_pin; // RULE_22
      pa_s2_r <= pa_s1_r;
      pa_s3_r <= pa_s2_r;
    end
  end

  // wake sources
  assign pin_wake = |(pa_s3_r & ~pa_s2_r & porta_wake_enable_r); // RULE_15
  assign irq_live = irq_flag & ~pre_r;               // RULE_18
  assign irq_wake = |irq_live;
  assign any_wake = pin_wake | irq_wake | wdt_overflow; // RULE_12

  // control register fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cks_r <= PMW_CTRL_RST[7:5];
      fss_r <= 1'b0;
      fhk_r <= 1'b0;
      fsk_r <= 1'b0;
    end else if (wr && paddr == PMW_CTRL_OFS) begin
      cks_r <= pwdata[PMW_CKS_LSB +: 3];
      fss_r <= pwdata[PMW_FSS_BIT];
      fhk_r <= pwdata[PMW_FHK_BIT];
      fsk_r <= pwdata[PMW_FSK_BIT];
    end
  end

  // wake and interrupt enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      porta_wake_enable_r  <= '0;
      irqen_r <= '0;
    end else if (wr && paddr == PMW_WAKE_OFS) begin
      porta_wake_enable_r <= pwdata[NPINS-1:0];
    end else if (wr && paddr == PMW_IRQEN_OFS) begin
      irqen_r <= pwdata[NIRQ-1:0];
    end
  end

  // fast rc: enabling it, or changing frequency while it stays enabled, restarts settling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frc_en_r <= PMW_FRC_RST[PMW_FRC_EN_BIT];
      frc_fq_r <= '0;
      frc_fl_r <= 1'b0;
      fxt_en_r <= 1'b0;
      fxt_fl_r <= 1'b0;
      fcnt_r   <= 16'(PMW_FAST_SET_CYC);
    end else begin
      if (wr && paddr == PMW_FASTRC_OFS) begin
        frc_en_r <= pwdata[PMW_FRC_EN_BIT];
        frc_fq_r <= pwdata[PMW_FRC_FQ_LSB +: 2];
        if (pwdata[PMW_FRC_EN_BIT] && (!frc_en_r || pwdata[PMW_FRC_FQ_LSB +: 2] != frc_fq_r)) begin
          frc_fl_r <= 1'b0; // RULE_20
          fcnt_r   <= 16'(PMW_FAST_SET_CYC);
        end
      end else if (wr && paddr == PMW_FASTXT_OFS) begin
        fxt_en_r <= pwdata[PMW_FXT_EN_BIT];
        if (pwdata[PMW_FXT_EN_BIT] && !fxt_en_r) begin
          fxt_fl_r <= 1'b0;
          fcnt_r   <= 16'(PMW_FAST_SET_CYC);
        end
      end else if (!clk_ctl.fast_on) begin
        // fast osc stopped: must resettle when restarted
        frc_fl_r <= 1'b0; // RULE_04
        fxt_fl_r <= 1'b0;
        fcnt_r   <= 16'(PMW_FAST_SET_CYC);
      end else if (fcnt_r != 16'h0000) begin
        fcnt_r <= fcnt_r - 16'h0001;
      end else begin
        frc_fl_r <= frc_en_r; // RULE_20
        fxt_fl_r <= fxt_en_r;
      end
    end
  end

  // slow oscillator settling model
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scnt_r  <= 16'(PMW_SLOW_SET_CYC);
      sstab_r <= 1'b0;
    end else if (!clk_ctl.slow_on) begin
      scnt_r  <= 16'(PMW_SLOW_SET_CYC);
      sstab_r <= 1'b0;
    end else if (scnt_r != 16'h0000) begin
      scnt_r <= scnt_r - 16'h0001;
    end else begin
      sstab_r <= 1'b1; // RULE_02
    end
  end

  // mode state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= PMW_NORMAL;
      sreq_r <= 1'b0;
    end else begin
      unique case (mode_r)
        PMW_NORMAL, PMW_SLOW: begin
          if (halt_strobe) begin
            // keep bits sampled on the halt cycle only
            unique case ({fhk_r, fsk_r}) // RULE_21
              2'b00: mode_r <= PMW_SLEEP;            // RULE_05
              2'b01: mode_r <= PMW_IDLE_SLOW_ONLY;   // RULE_06
              2'b11: mode_r <= PMW_IDLE_BOTH_CLOCKS; // RULE_07
              2'b10: mode_r <= PMW_IDLE_FAST_ONLY;   // RULE_08
            endcase
          end else if (cks_r == PMW_CKS_SLOW && mode_r == PMW_NORMAL) begin
            if (sstab_r) begin
              mode_r <= PMW_SLOW; // RULE_01 RULE_02
            end
          end else if (cks_r != PMW_CKS_SLOW && mode_r == PMW_SLOW) begin
            if (fast_stable) begin
              mode_r <= PMW_NORMAL; // RULE_03 RULE_04
            end
          end
          sreq_r <= (cks_r == PMW_CKS_SLOW);
        end
        default: begin
          // resume in the mode the clock select implies
          if (any_wake) begin
            mode_r <= (cks_r == PMW_CKS_SLOW) ? PMW_SLOW : PMW_NORMAL;
          end
        end
      endcase
    end
  end

  // capture flags already pending at halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (halt_strobe && !halted) begin
      pre_r <= irq_flag; // RULE_18
    end else if (!halted) begin
      pre_r <= '0;
    end
  end

  // power-down and timeout flags; halt set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdf_r <= 1'b0;
      to_r  <= 1'b0;
    end else begin
      if (halt_strobe && !halted) begin
        pdf_r <= 1'b1; // RULE_10 RULE_13
        to_r  <= 1'b0; // RULE_10
      end else if (wdt_clear_strobe || (wr && paddr == PMW_CMD_OFS && pwdata[PMW_CMD_WDCLR_BIT])) begin
        pdf_r <= 1'b0; // RULE_13
        to_r  <= 1'b0;
      end
      if (halted && wdt_overflow) begin
        to_r <= 1'b1; // RULE_14
      end
    end
  end

  // wake event pulses to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_sp_reset <= 1'b0;
      wake_resume <= 1'b0;
      irq_take    <= 1'b0;
      wdt_clear   <= 1'b0;
    end else begin
      wdt_clear   <= halt_strobe && !halted; // RULE_11
      pc_sp_reset <= halted && wdt_overflow; // RULE_14
      wake_resume <= halted && !wdt_overflow && any_wake; // RULE_15 RULE_16
      // disabled or stack full: leave pending, no response
      irq_take    <= halted && !wdt_overflow && |(irq_live & irqen_r) && !stack_full; // RULE_17 RULE_16
    end
  end

  // clock gating outputs, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctl <= '{fast_on: 1'b1, slow_on: 1'b1, slow_rc_on: 1'b1,
                   slow_is_crystal: 1'b0, sys_is_slow: 1'b0, fast_div: 3'h0, cpu_run: 1'b1};
    end else begin
      clk_ctl.fast_on <= !(mode_r == PMW_SLEEP || mode_r == PMW_IDLE_SLOW_ONLY ||
                           (mode_r == PMW_SLOW && !fhk_r && !sreq_r && 1'b0)) ; // RULE_05 RULE_06
      clk_ctl.slow_on <= !(mode_r == PMW_SLEEP || mode_r == PMW_IDLE_FAST_ONLY); // RULE_08
      // watchdog needs the slow rc regardless of keep bit
      clk_ctl.slow_rc_on <= wdt_enabled ||
                            (!fss_r && !(mode_r == PMW_SLEEP || mode_r == PMW_IDLE_FAST_ONLY)); // RULE_19
      clk_ctl.slow_is_crystal <= fss_r; // RULE_02
      clk_ctl.sys_is_slow     <= (mode_r == PMW_SLOW); // RULE_01
      clk_ctl.fast_div        <= (cks_r == PMW_CKS_SLOW) ? 3'h0 : cks_r; // RULE_03
      clk_ctl.cpu_run         <= !halted && !(halt_strobe); // RULE_09 RULE_07
    end
  end

  assign cpu_run = clk_ctl.cpu_run;

  // read data mux, registered for stable data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        PMW_CTRL_OFS:   prdata <= 32'({cks_r, 2'b00, fss_r, fhk_r, fsk_r});
        PMW_STAT_OFS:   prdata <= 32'({1'b0, mode_r, 2'b00, to_r, pdf_r});
        PMW_WAKE_OFS:   prdata <= 32'(porta_wake_enable_r);
        PMW_IRQEN_OFS:  prdata <= 32'(irqen_r);
        PMW_FASTRC_OFS: prdata <= 32'({frc_fq_r, frc_fl_r, frc_en_r});
        PMW_FASTXT_OFS: prdata <= 32'({fxt_fl_r, fxt_en_r});
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : pmw_ctrl

// [dv/pmw_ctrl_sva.sv]
// checker for the power mode and wake controller
`timescale 1ns/1ns
module pmw_ctrl_sva
  import pmw_pkg::*;
#(
  parameter int NPINS = 8, // port a pins
  parameter int NIRQ  = 8  // irq sources
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic [31:0]      prdata,
  input wire logic             pslverr,
  input wire logic             halt_strobe,
  input wire logic             wdt_clear_strobe,
  input wire logic             wdt_overflow,
  input wire logic             wdt_enabled,
  input wire logic             stack_full,
  input wire logic [NPINS-1:0] porta_pin,
  input wire logic [NIRQ-1:0]  irq_flag,
  input wire logic             cpu_run,
  input wire logic             wdt_clear,
  input wire logic             pc_sp_reset,
  input wire logic             wake_resume,
  input wire logic             irq_take,
  input wire pmw_clk_s         clk_ctl
);
  logic [7:0]       ctrl_sh_r; // last control word written
  logic [NPINS-1:0] wake_sh_r; // last pin enables written
  logic             wr_ok;     // write completes this edge
  assign wr_ok = psel && penable && pwrite && pready;
  // shadows, since the body is hidden from us
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sh_r <= PMW_CTRL_RST;
      wake_sh_r <= '0;
    end else if (wr_ok && paddr == PMW_CTRL_OFS) begin
      ctrl_sh_r <= pwdata[7:0];
    end else if (wr_ok && paddr == PMW_WAKE_OFS) begin
      wake_sh_r <= pwdata[NPINS-1:0];
    end
  end
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && penable |-> pready && pslverr == (paddr > PMW_CMD_OFS))
    else $error("apb answer wrong");
  halt_stop_a: assert property (halt_strobe && cpu_run |=> !cpu_run)
    else $error("core runs after halt");
  halt_wdt_a: assert property (halt_strobe && cpu_run |-> ##[1:2] wdt_clear)
    else $error("no watchdog clear on halt");
  halt_clk_a: assert property (halt_strobe && cpu_run |-> ##[1:2]
    (clk_ctl.fast_on == ctrl_sh_r[PMW_FHK_BIT] && clk_ctl.slow_on == ctrl_sh_r[PMW_FSK_BIT]))
    else $error("clock gates disagree with keep bits");
  pin_wake_a: assert property (!cpu_run && $fell(porta_pin[0]) && wake_sh_r[0]
    |-> ##[1:6] wake_resume) else $error("enabled pin edge did not wake");
  ovf_halt_a: assert property (!cpu_run && wdt_overflow |-> ##[1:2] pc_sp_reset)
    else $error("overflow while halted lost");
  take_gate_a: assert property (irq_take |-> !$past(stack_full))
    else $error("interrupt taken with stack full");
  rc_wdt_a: assert property (wdt_enabled && !cpu_run && !$past(cpu_run) |-> clk_ctl.slow_rc_on)
    else $error("slow rc off under watchdog");
  slow_sel_a: assert property (wr_ok && paddr == PMW_CTRL_OFS &&
    pwdata[7:5] == PMW_CKS_SLOW |-> ##[1:600] clk_ctl.sys_is_slow) else $error("slow mode not reached");
  sleep_c: cover property (halt_strobe && cpu_run && ctrl_sh_r[1:0] == 2'h0);
  take_c: cover property (irq_take);
  pcsp_c: cover property (pc_sp_reset);
endmodule : pmw_ctrl_sva

bind pmw_ctrl pmw_ctrl_sva #(.NPINS(NPINS), .NIRQ(NIRQ)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .halt_strobe(halt_strobe),
  .wdt_clear_strobe(wdt_clear_strobe), .wdt_overflow(wdt_overflow), .wdt_enabled(wdt_enabled),
  .stack_full(stack_full), .porta_pin(porta_pin), .irq_flag(irq_flag), .cpu_run(cpu_run),
  .wdt_clear(wdt_clear), .pc_sp_reset(pc_sp_reset), .wake_resume(wake_resume), .irq_take(irq_take),
  .clk_ctl(clk_ctl)
);

// [dv/pmw_ctrl_tb_top.sv]
// self-checking testbench for the power mode and wake controller
`timescale 1ns/1ns
module pmw_ctrl_tb_top import pmw_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr; // clock, reset, apb
  logic [7:0]  paddr;                                                 // apb address
  logic [31:0] pwdata, prdata, rd;                                    // apb data, last read
  logic        halt_strobe, wdt_clear_strobe, wdt_overflow, wdt_enabled, stack_full; // core side
  logic [7:0]  porta_pin, irq_flag;                                   // pins and requests
  logic        cpu_run, wdt_clear, pc_sp_reset, wake_resume, irq_take; // core outputs
  pmw_clk_s    clk_ctl;                                               // clock gates
  logic        er, tk_s, wr_s, ps_s, wc_s;                            // slave error, pulse catches
  int          fail_count, compares, cyc;                             // tallies
  pmw_mode_e   hm [4] = '{PMW_SLEEP, PMW_IDLE_SLOW_ONLY, PMW_IDLE_FAST_ONLY, PMW_IDLE_BOTH_CLOCKS};
  logic [7:0]  req [4] = '{8'h1, 8'h2, 8'h1, 8'h4};                   // line 1 left disabled

  pmw_ctrl #(.NPINS(8), .NIRQ(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .halt_strobe(halt_strobe),
    .wdt_clear_strobe(wdt_clear_strobe), .wdt_overflow(wdt_overflow), .wdt_enabled(wdt_enabled),
    .stack_full(stack_full), .porta_pin(porta_pin), .irq_flag(irq_flag), .cpu_run(cpu_run),
    .wdt_clear(wdt_clear), .pc_sp_reset(pc_sp_reset), .wake_resume(wake_resume), .irq_take(irq_take),
    .clk_ctl(clk_ctl)
  );

  always #4 pclk = ~pclk;
  // catch one-cycle pulses; cut a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (irq_take === 1'b1) tk_s <= 1'b1;
    if (wake_resume === 1'b1) wr_s <= 1'b1;
    if (pc_sp_reset === 1'b1) ps_s <= 1'b1;
    if (wdt_clear === 1'b1) wc_s <= 1'b1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; holds until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] st(input pmw_mode_e m, input logic t, input logic p);
    return {25'h0, m, 2'h0, t, p};
  endfunction : st

  task automatic wt_slow(input logic v);
    for (int i = 0; i < 800 && clk_ctl.sys_is_slow !== v; i++) @(posedge pclk);
    #1;
    chk("sys slow", {31'h0, v}, {31'h0, clk_ctl.sys_is_slow});
  endtask : wt_slow

  // wake latency is the design's own, so poll with a bound
  task automatic wait_run();
    for (int i = 0; i < 200 && cpu_run !== 1'b1; i++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    #1;
    chk("cpu run", 32'h1, {31'h0, cpu_run});
  endtask : wait_run

  task automatic halt_go(input logic [1:0] k);
    apb(1'b1, PMW_CTRL_OFS, {30'h0, k});
    @(posedge pclk);
    {tk_s, wr_s, ps_s, wc_s} <= 4'h0;
    halt_strobe <= 1'b1;
    @(posedge pclk);
    halt_strobe <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk("halted", 32'h0, {31'h0, cpu_run});
    chk("gates", {30'h0, k}, {30'h0, clk_ctl.fast_on, clk_ctl.slow_on});
    chk("slow rc", 32'h1, {31'h0, clk_ctl.slow_rc_on});
    chk("wdt clear", 32'h1, {31'h0, wc_s});
  endtask : halt_go

  task automatic pin_wake();
    @(posedge pclk);
    porta_pin[0] <= 1'b0;
    wait_run();
    chk("pin wake", 32'h1, {31'h0, wr_s});
    @(posedge pclk);
    porta_pin[0] <= 1'b1;
  endtask : pin_wake

  initial begin
    {psel, penable, pwrite, halt_strobe, wdt_clear_strobe, wdt_overflow, stack_full, presetn, pclk} = 9'h0;
    {paddr, pwdata, irq_flag, tk_s, wr_s, ps_s, wc_s} = 52'h0;
    porta_pin = 8'hff;
    wdt_enabled = 1'b1;
    {fail_count, compares, cyc} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and a word past the map
    apb(1'b0, PMW_CTRL_OFS, 32'h0);
    chk("ctrl", {24'h0, PMW_CTRL_RST}, rd);
    apb(1'b0, PMW_STAT_OFS, 32'h0);
    chk("status", st(PMW_NORMAL, 1'b0, 1'b0), rd);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("slverr", 32'h1, {31'h0, er});
    // slow source select reaches the clock gates one edge later
    apb(1'b1, PMW_CTRL_OFS, 32'h1 << PMW_FSS_BIT);
    @(posedge pclk);
    #1;
    chk("slow src", 32'h1, {31'h0, clk_ctl.slow_is_crystal});
    // slow mode, fast rc restarted, then every divider
    apb(1'b1, PMW_CTRL_OFS, {24'h0, PMW_CKS_SLOW, 5'h0});
    wt_slow(1'b1);
    apb(1'b0, PMW_STAT_OFS, 32'h0);
    chk("status", st(PMW_SLOW, 1'b0, 1'b0), rd);
    apb(1'b1, PMW_FASTRC_OFS, 32'h0);
    apb(1'b1, PMW_FASTRC_OFS, 32'h1);
    apb(1'b0, PMW_FASTRC_OFS, 32'h0);
    chk("rc stable", 32'h0, {31'h0, rd[PMW_FRC_FL_BIT]});
    for (int c = 6; c >= 0; c--) begin
      apb(1'b1, PMW_CTRL_OFS, 32'(c) << PMW_CKS_LSB);
      wt_slow(1'b0);
      apb(1'b0, PMW_FASTRC_OFS, 32'h0);
      chk("rc stable", 32'h1, {31'h0, rd[PMW_FRC_FL_BIT]});
      chk("divider", 32'(c), {29'h0, clk_ctl.fast_div});
    end
    // all four halt modes, each left by a pin edge
    apb(1'b1, PMW_WAKE_OFS, 32'h1);
    for (int k = 0; k < 4; k++) begin
      halt_go(2'(k));
      apb(1'b0, PMW_STAT_OFS, 32'h0);
      chk("status", st(hm[k], 1'b0, 1'b1), rd);
      pin_wake();
    end
    // disabled pin is ignored; overflow wakes with timeout set
    halt_go(2'h0);
    @(posedge pclk);
    porta_pin[1] <= 1'b0;
    repeat (10) @(posedge pclk);
    #1;
    chk("asleep", 32'h0, {31'h0, cpu_run});
    @(posedge pclk);
    wdt_overflow <= 1'b1;
    porta_pin[1] <= 1'b1;
    @(posedge pclk);
    wdt_overflow <= 1'b0;
    wait_run();
    chk("pc sp reset", 32'h1, {31'h0, ps_s});
    apb(1'b0, PMW_STAT_OFS, 32'h0);
    chk("status", st(PMW_NORMAL, 1'b1, 1'b1), rd);
    // interrupt wake: taken, disabled, stack full, already pending
    apb(1'b1, PMW_IRQEN_OFS, 32'h5);
    for (int n = 0; n < 4; n++) begin
      @(posedge pclk);
      stack_full <= (n == 2);
      irq_flag <= (n == 3) ? req[n] : 8'h0;
      halt_go(2'h0);
      @(posedge pclk);
      irq_flag <= req[n];
      if (n == 3) begin
        repeat (20) @(posedge pclk);
        #1;
        chk("pending stays asleep", 32'h0, {31'h0, cpu_run});
        pin_wake();
      end else begin
        wait_run();
        chk("irq take", {31'h0, n == 0}, {31'h0, tk_s});
      end
      @(posedge pclk);
      irq_flag <= 8'h0;
      stack_full <= 1'b0;
    end
    // power-down flag cleared by strobe and by command word
    @(posedge pclk);
    wdt_clear_strobe <= 1'b1;
    @(posedge pclk);
    wdt_clear_strobe <= 1'b0;
    apb(1'b0, PMW_STAT_OFS, 32'h0);
    chk("status", st(PMW_NORMAL, 1'b0, 1'b0), rd);
    halt_go(2'h3);
    pin_wake();
    apb(1'b1, PMW_CMD_OFS, 32'h1);
    apb(1'b0, PMW_STAT_OFS, 32'h0);
    chk("status", st(PMW_NORMAL, 1'b0, 1'b0), rd);
    print_verdict();
  end
endmodule : pmw_ctrl_tb_top
